// [core/tsie_stage_irq.v]
// Stage interrupt masks, high-limit status and interrupt output
`timescale 1ns/10ps
`default_nettype none
`include "tsie_consts.vh"

// Operation
// - The high-limit mask at 0x006 is readable and writable, bit n for stage n, reset to zero.
// - An enabled stage whose result is over its high threshold drives the interrupt output.
// - A stage whose high-limit mask bit is zero never contributes its high-limit status to the interrupt output.
// - The high-limit mask covers stages 0 to 11 on bits 0 to 11, upper bits unused.
// - The conversion-done mask at 0x007 is readable and writable, bit n for stage n, reset zero.
// - An enabled stage drives the interrupt output when its conversion finishes.
// - A read-only high-limit status bit per stage at 0x009 is set when the limit was exceeded.
// - Status bits clear after the host reads them, unless the limit is still exceeded.
module tsie_stage_irq (
    input wire clk, // 200 MHz clock
    input wire reset_n, // Asynchronous reset, active low
    input wire ce, // Clock enable, freezes all state except the reset synchronizer when low
    input wire [`TSIE_ADDR_W-1:0] reg_addr, // Register address
    input wire [`TSIE_DATA_W-1:0] reg_wdata, // Register write data
    input wire reg_wr, // Write strobe, one cycle
    input wire reg_rd, // Read strobe, one cycle
    input wire [`TSIE_STAGES-1:0] stage_over_high, // Result above high threshold, level
    input wire [`TSIE_STAGES-1:0] stage_done, // Conversion finished, one-cycle pulse
    output reg [`TSIE_DATA_W-1:0] reg_rdata_q, // Read data, valid the cycle after reg_rd
    output reg int_n_q // Interrupt output, active low
);

    localparam PAD_W = `TSIE_DATA_W - `TSIE_STAGES;

    // Reset release path
    reg rst_meta_q;
    reg rst_sync_q;

    // Host-visible masks, bit n for stage n
    reg [`TSIE_STAGES-1:0] high_mask_q;
    reg [`TSIE_STAGES-1:0] done_mask_q;
    wire [`TSIE_STAGES-1:0] high_mask_d;
    wire [`TSIE_STAGES-1:0] done_mask_d;

    // Event memory: visible high status and hidden done pending
    reg [`TSIE_STAGES-1:0] high_stat_q;
    reg [`TSIE_STAGES-1:0] done_pend_q;
    wire [`TSIE_STAGES-1:0] high_stat_d;
    wire [`TSIE_STAGES-1:0] done_pend_d;

    // Per-stage sources after masking
    wire [`TSIE_STAGES-1:0] high_src;
    wire [`TSIE_STAGES-1:0] done_src;
    wire any_high;
    wire any_done;
    wire any_src;
    reg int_n_d;

    // Register port decode
    wire sel_high_mask;
    wire sel_done_mask;
    wire sel_high_stat;
    wire wr_high_mask;
    wire wr_done_mask;
    wire stat_rd;
    reg [`TSIE_DATA_W-1:0] rdata_d;

    genvar i;
    genvar j;
    genvar k;

    function hit;
        input [`TSIE_ADDR_W-1:0] a;
        input [`TSIE_ADDR_W-1:0] target;
        begin
            hit = (a == target);
        end
    endfunction

    // Stored fields are 12 bits; the bus word is always 16
    function [`TSIE_DATA_W-1:0] pad_word;
        input [`TSIE_STAGES-1:0] v;
        begin
            pad_word = {{PAD_W{1'b0}}, v};
        end
    endfunction

    // Write-enable merge shared by both masks
    function write_bit;
        input held;
        input we;
        input wbit;
        begin
            if (we) begin
                write_bit = wbit;
            end else begin
                write_bit = held;
            end
        end
    endfunction

    // Set wins over clear, so an event in the read cycle is never lost
    function event_bit;
        input held;
        input clr;
        input fresh;
        begin
            event_bit = (held & ~clr) | fresh;
        end
    endfunction

    // Reset released through two flops
    // All state flops then leave reset on the same edge
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    assign sel_high_mask = hit(reg_addr, `TSIE_ADDR_HIGH_MASK);
    assign sel_done_mask = hit(reg_addr, `TSIE_ADDR_DONE_MASK);
    assign sel_high_stat = hit(reg_addr, `TSIE_ADDR_HIGH_STAT);
    assign wr_high_mask = reg_wr && sel_high_mask;
    assign wr_done_mask = reg_wr && sel_done_mask;
    assign stat_rd = reg_rd && sel_high_stat;

    // Upper data bits are unused, so writes to them are dropped
    generate
        for (i = 0; i < `TSIE_STAGES; i = i + 1) begin : g_mask
            assign high_mask_d[i] = write_bit(high_mask_q[i], wr_high_mask, reg_wdata[i]);
            assign done_mask_d[i] = write_bit(done_mask_q[i], wr_done_mask, reg_wdata[i]);
        end
    endgenerate

    // A done pulse lasts one cycle, so it is held until the next status read;
    // the pending bits are not visible to the host
    generate
        for (j = 0; j < `TSIE_STAGES; j = j + 1) begin : g_event
            assign high_stat_d[j] = event_bit(high_stat_q[j], stat_rd, stage_over_high[j]);
            assign done_pend_d[j] = event_bit(done_pend_q[j], stat_rd, stage_done[j]);
        end
    endgenerate

    // Masked-off stages still record events but never reach the pin
    generate
        for (k = 0; k < `TSIE_STAGES; k = k + 1) begin : g_source
            assign high_src[k] = high_mask_q[k] & high_stat_q[k];
            assign done_src[k] = done_mask_q[k] & done_pend_q[k];
        end
    endgenerate

    assign any_high = |high_src;
    assign any_done = |done_src;
    assign any_src = any_high | any_done;

    // Pin is active low
    always @* begin
        int_n_d = ~any_src;
    end

    // Unmapped addresses read as zero
    always @* begin
        rdata_d = {`TSIE_DATA_W{1'b0}};
        case (reg_addr)
            `TSIE_ADDR_HIGH_MASK: begin
                rdata_d = pad_word(high_mask_q);
            end
            `TSIE_ADDR_DONE_MASK: begin
                rdata_d = pad_word(done_mask_q);
            end
            `TSIE_ADDR_HIGH_STAT: begin
                rdata_d = pad_word(high_stat_q);
            end
            default: begin
                rdata_d = {`TSIE_DATA_W{1'b0}};
            end
        endcase
    end

    // Masks; a read and a write of the same mask in one cycle
    // return the value from before the write
    always @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            high_mask_q <= `TSIE_MASK_RESET;
            done_mask_q <= `TSIE_MASK_RESET;
        end else if (ce) begin
            high_mask_q <= high_mask_d;
            done_mask_q <= done_mask_d;
        end
    end

    // Event memory; events seen while ce is low are not recorded
    always @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            high_stat_q <= `TSIE_STAT_RESET;
            done_pend_q <= `TSIE_STAT_RESET;
        end else if (ce) begin
            high_stat_q <= high_stat_d;
            done_pend_q <= done_pend_d;
        end
    end

    // Read data holds until the next read
    always @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            reg_rdata_q <= `TSIE_RDATA_RESET;
        end else if (ce && reg_rd) begin
            reg_rdata_q <= rdata_d;
        end
    end

    // Registered so the pin cannot glitch while sources change
    always @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            int_n_q <= 1'b1;
        end else if (ce) begin
            int_n_q <= int_n_d;
        end
    end

endmodule
`default_nettype wire

// [core/tsie_consts.vh]
// Constants for the stage interrupt enable block
`ifndef TSIE_CONSTS_VH
`define TSIE_CONSTS_VH
`define TSIE_ADDR_W 10
`define TSIE_DATA_W 16
`define TSIE_STAGES 12
`define TSIE_ADDR_HIGH_MASK 10'h006
`define TSIE_ADDR_DONE_MASK 10'h007
`define TSIE_ADDR_HIGH_STAT 10'h009
`define TSIE_MASK_RESET 12'h000
`define TSIE_STAT_RESET 12'h000
`define TSIE_RDATA_RESET 16'h0000
`endif

// [test/tsie_stage_irq_properties.sv]
// Checker for the stage interrupt block
`timescale 1ns/10ps
`default_nettype none
module tsie_chk (
    input wire logic clk, reset_n, ce, reg_wr, reg_rd, int_n_q, // Control
    input wire logic [9:0] reg_addr, // Address
    input wire logic [15:0] reg_wdata, reg_rdata_q, // Data
    input wire logic [11:0] stage_over_high, stage_done // Events
);
    logic [11:0] hm, dm;
    wire r = ce && reg_rd;
    wire w = ce && reg_wr;
    // Shadow masks; bench keeps writes clear of the internal reset tail
    always @(posedge clk or negedge reset_n)
        if (!reset_n) {hm, dm} <= 24'h0;
        else if (w) {hm, dm} <= {reg_addr == 6 ? reg_wdata[11:0] : hm,
            reg_addr == 7 ? reg_wdata[11:0] : dm};
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_hi_int: assert property (|(stage_over_high & hm) && ce ##1 ce[*2] |-> !int_n_q)
        else $error("high event missed");
    a_done_int: assert property (|(stage_done & dm) && ce ##1 ce[*2] |-> !int_n_q)
        else $error("done event missed");
    a_rd_hmask: assert property (r && reg_addr == 6 |=> reg_rdata_q == {4'h0, $past(hm)})
        else $error("high mask read");
    a_rd_dmask: assert property (r && reg_addr == 7 |=> reg_rdata_q == {4'h0, $past(dm)})
        else $error("done mask read");
    a_upper_zero: assert property (r |=> reg_rdata_q[15:12] == 0) else $error("upper bits");
    a_quiet_mask: assert property ($fell(int_n_q) |-> |{hm, dm}) else $error("masked irq");
    a_int_release: assert property ($rose(int_n_q) |-> $past(r || w, 2)) else $error("rel");
    a_rd_hold: assert property (!r |=> $stable(reg_rdata_q)) else $error("rdata moved");
    c_fall: cover property ($fell(int_n_q));
    c_rise: cover property ($rose(int_n_q));
    c_stat: cover property (r && reg_addr == 9);
endmodule
bind tsie_stage_irq tsie_chk u_chk (.*);
`default_nettype wire

// [test/tsie_host_model.sv]
// Host register access model
`timescale 1ns/10ps
`default_nettype none
module tsie_host_model (
    input wire logic clk, // Clock
    output var logic [9:0] reg_addr = 0, // Address
    output var logic [15:0] reg_wdata = 0, // Data
    output var logic reg_wr = 0, reg_rd = 0 // Strobes
);
    task acc(logic [9:0] a, logic [15:0] d, logic w);
        @(posedge clk) #1 {reg_addr, reg_wdata, reg_wr, reg_rd} = {a, 4'h0, d[11:0], w, !w};
        @(posedge clk) #1 {reg_addr, reg_wdata, reg_wr, reg_rd} = {~a, ~d, 2'b0};
    endtask
endmodule
`default_nettype wire

// [test/tsie_stage_irq_tb.sv]
// Bench for the stage interrupt block
`timescale 1ns/10ps
`default_nettype none
module tsie_stage_irq_tb;
    logic clk = 0, reset_n = 0, reg_wr, reg_rd, int_n_q;
    logic [9:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata_q;
    logic [11:0] hi = 0, dn = 0;
    logic ce = 1;
    int n_fail = 0, n_tests = 0;
    tsie_host_model host (.*);
    tsie_stage_irq dut (.ce(ce), .stage_over_high(hi), .stage_done(dn), .*);
    initial forever #2.5 clk = ~clk;
    task chk(string s, logic [15:0] v, e);
        n_tests++;
        if (v !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", s, e, v);
        end
    endtask
    task give_verdict;
        if (n_fail == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task rd(logic [9:0] a, logic [15:0] e);
        host.acc(a, 0, 0);
        chk("rdata", reg_rdata_q, e);
    endtask
    task ev(logic [11:0] h, d, logic e);
        @(posedge clk) #1 {hi, dn} = {h, d};
        @(posedge clk) #1 {hi, dn} = 24'h0;
        repeat (2) @(posedge clk);
        #1 chk("int", int_n_q, e);
    endtask
    task t_regs;
        rd(6, 0);
        rd(7, 0);
        host.acc(6, 16'h0a5c, 1);
        host.acc(7, 16'h05a3, 1);
        rd(6, 16'h0a5c);
        rd(7, 16'h05a3);
        host.acc(6, 0, 1);
    endtask
    task t_irq;
        host.acc(7, 1, 1);
        ev(12'h800, 0, 1);
        rd(9, 16'h0800);
        rd(9, 0);
        host.acc(6, 16'h0800, 1);
        ev(12'h800, 0, 0);
        rd(9, 16'h0800);
        @(posedge clk) #1 chk("int", int_n_q, 1);
        host.acc(6, 0, 1);
        ev(0, 12'h001, 0);
        rd(9, 0);
        @(posedge clk) #1 chk("int", int_n_q, 1);
        ev(0, 12'h002, 1);
        rd(9, 0);
        host.acc(6, 16'h0800, 1);
        ev(12'h800, 12'h001, 0);
        rd(9, 16'h0800);
        @(posedge clk) #1 chk("int", int_n_q, 1);
    endtask
    task t_hold;
        @(posedge clk) #1 hi = 12'h001;
        rd(9, 16'h0001);
        rd(9, 16'h0001);
        @(posedge clk) #1 hi = 0;
        rd(9, 16'h0001);
        rd(9, 0);
        chk("int", int_n_q, 1);
    endtask
    task t_ce;
        @(posedge clk) #1 {ce, hi} = {1'b0, 12'h004};
        host.acc(6, 16'h0fff, 1);
        @(posedge clk) #1 {ce, hi} = {1'b1, 12'h000};
        rd(6, 16'h0800);
        rd(9, 0);
    endtask
    task t_reset;
        host.acc(7, 16'h00f0, 1);
        rd(7, 16'h00f0);
        @(posedge clk) #1 reset_n = 0;
        repeat (2) @(posedge clk);
        #1 reset_n = 1;
        repeat (3) @(posedge clk);
        #1 chk("int", int_n_q, 1);
        chk("rdata", reg_rdata_q, 0);
        rd(6, 0);
        rd(7, 0);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        #1 reset_n = 1;
        repeat (3) @(posedge clk);
        #1 chk("int", int_n_q, 1);
        chk("rdata", reg_rdata_q, 0);
        t_regs;
        t_irq;
        t_hold;
        t_ce;
        t_reset;
        give_verdict;
    end
    initial begin
        #4000 n_fail++;
        give_verdict;
    end
endmodule
`default_nettype wire
